//--- half_bridge_fault_control_tb.sv
// Testbench: drives the fault control through the controller model and its sense inputs.
module half_bridge_fault_control_tb;
    import hbfc_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct packed {
        logic [15:0] w;
        logic        pwm;
        logic [5:0]  ol, sw, src, st, msk;
        logic        sb;
    } hbfc_row_type;

    logic              CLK_SYS_I, RSTN_I, SPI_CLK_I, CS_N_I, DI_I, DO_O, PWM_I, UV_I, PREWARN_I;
    logic [NUM_SW-1:0] TSD_I, OC_I, OL_I, SW_ON_O, OL_SRC_O;
    logic [15:0]       STATUS_O, rx;
    int                n_mismatch  = 0;
    int                comparisons = 0;
    logic [15:0]       pats [3] = '{TEST_PAT_A, TEST_PAT_B, TEST_PAT_C};
    // Word, pwm, open-load sense, drive, sources, status, status mask, standby
    hbfc_row_type      rows [9] = '{
        '{16'hA02A, 1'b0, 6'h00, 6'h15, 6'h00, 6'h15, 6'h3F, 1'b0},
        '{16'h8054, 1'b0, 6'h00, 6'h2A, 6'h15, 6'h2A, 6'h3F, 1'b0},
        '{16'h2054, 1'b0, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 1'b1},
        '{16'hA104, 1'b0, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 1'b0},
        '{16'hA104, 1'b1, 6'h00, 6'h02, 6'h00, 6'h02, 6'h3F, 1'b0},
        '{16'hA080, 1'b1, 6'h00, 6'h00, 6'h00, 6'h00, 6'h3F, 1'b0},
        '{16'h8002, 1'b0, 6'h04, 6'h01, 6'h3E, 6'h05, 6'h3F, 1'b0},
        '{16'h8004, 1'b0, 6'h08, 6'h02, 6'h3D, 6'h0A, 6'h3F, 1'b0},
        '{16'h8004, 1'b0, 6'h00, 6'h02, 6'h3D, 6'h02, 6'h3F, 1'b0}
    };

    hbfc_fault_ctrl #(.OC_TRIP_DELAY_NS(100)) dut (.CLK_SYS_I(CLK_SYS_I), .RSTN_I(RSTN_I), .SPI_CLK_I(SPI_CLK_I),
        .CS_N_I(CS_N_I), .DI_I(DI_I), .DO_O(DO_O), .PWM_I(PWM_I), .UV_I(UV_I), .PREWARN_I(PREWARN_I),
        .TSD_I(TSD_I), .OC_I(OC_I), .OL_I(OL_I), .SW_ON_O(SW_ON_O), .OL_SRC_O(OL_SRC_O), .STATUS_O(STATUS_O));
    hbfc_mcu_model mcu (.spi_clk_o(SPI_CLK_I), .cs_n_o(CS_N_I), .di_o(DI_I), .do_i(DO_O));

    // 50 MHz system clock
    initial begin
        CLK_SYS_I = 1'b0;
        forever #10 CLK_SYS_I = ~CLK_SYS_I;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Flags in the top bits, switch drive in the low six
    task automatic st(input logic [15:0] exp, input string what);
        chk({STATUS_O[15:13], 7'h00, SW_ON_O}, exp, what);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge CLK_SYS_I);
    endtask

    task automatic wr(input logic [15:0] w);
        mcu.xfer(w, 16, rx);
        cyc(12);
    endtask

    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Watchdog: the whole sequence needs well under 0.2 ms
    initial begin
        #1000000;
        n_mismatch++;
        final_report;
    end

    initial begin
        RSTN_I = 1'b0; PWM_I = 1'b0; UV_I = 1'b0; PREWARN_I = 1'b0;
        TSD_I = 6'h00; OC_I = 6'h00; OL_I = 6'h00;
        repeat (3) @(posedge CLK_SYS_I);
        @(negedge CLK_SYS_I);
        RSTN_I = 1'b1;
        cyc(5);
        chk({4'h0, SW_ON_O, OL_SRC_O}, 16'h0000, "reset drive");
        mcu.xfer(16'hE000, 16, rx);
        chk(rx, 16'h0000, "reset status word");
        cyc(12);
        // Ordinary cases; PWM held static, far below its rate ceiling
        foreach (rows[i]) begin
            PWM_I = rows[i].pwm;
            OL_I  = rows[i].ol;
            wr(rows[i].w);
            chk({4'h0, SW_ON_O, OL_SRC_O}, {4'h0, rows[i].sw, rows[i].src}, "drive");
            chk({9'h000, STATUS_O[14], STATUS_O[6:1] & rows[i].msk}, {9'h000, rows[i].sb, rows[i].st}, "status");
        end
        // Short read of the prewarning, frame aborted
        PREWARN_I = 1'b1;
        cyc(10);
        chk({15'h0000, STATUS_O[0]}, 16'h0001, "prewarn set");
        mcu.xfer(16'h0000, 3, rx);
        chk({15'h0000, rx[0]}, 16'h0001, "prewarn at select");
        cyc(12);
        chk({10'h000, SW_ON_O}, 16'h0002, "aborted frame");
        PREWARN_I = 1'b0;
        cyc(10);
        chk({15'h0000, STATUS_O[0]}, 16'h0000, "prewarn clear");
        wr(16'hE02A);
        foreach (pats[i]) begin
            wr(pats[i]);
            st(16'h0015, "test pattern refused");
        end
        // Undervoltage: short dip filtered, long one latches
        UV_I = 1'b1;
        cyc(400);
        UV_I = 1'b0;
        cyc(10);
        st(16'h0015, "short dip");
        UV_I = 1'b1;
        cyc(560);
        st(16'h8000, "undervoltage");
        UV_I = 1'b0;
        cyc(10);
        st(16'h8015, "supply back");
        wr(16'hE02B);
        st(16'h0015, "fail cleared");
        // Armed overcurrent after a reset word: the reset must not linger
        OC_I = 6'h01;
        cyc(30);
        OC_I = 6'h00;
        cyc(20);
        st(16'h2014, "overcurrent trip");
        chk({15'h0000, STATUS_O[1]}, 16'h0000, "tripped status bit");
        wr(16'hE02B);
        chk(rx, 16'h2028, "trip read back");
        st(16'h0015, "overload cleared");
        wr(16'hA02A);
        OC_I = 6'h04;
        cyc(30);
        st(16'h0015, "disarmed overcurrent");
        OC_I = 6'h00;
        // Thermal stop: reset word only helps once cool
        TSD_I = 6'h10;
        cyc(10);
        st(16'h2005, "thermal stop");
        chk({15'h0000, STATUS_O[5]}, 16'h0000, "hot status bit");
        wr(16'hA02B);
        st(16'h2005, "reset while hot");
        TSD_I = 6'h00;
        cyc(10);
        st(16'h2005, "cool, no word");
        wr(16'hA02B);
        st(16'h0015, "cool and reset");
        final_report;
    end
endmodule

//--- hbfc_fault_ctrl.sv
// Top of the half-bridge fault control: input register, protection latches and output drive.
//
// Summary of operation
// - Input register wakes with bits 15 to 13 high, the rest low.
// - Undervoltage lasting past the filter delay sets supply-fail and disables all outputs.
// - Outputs come back at once when the load supply recovers.
// - Supply-fail stays latched until the status reset command is written high.
// - With open-load test control low, sensing sources are on for every switch not switched on.
// - Open-load state of each switch is reported in output bits 1 to 6.
// - A switched-on output has its open-load sensing turned off, only that one.
// - Bridge check: low switch x then high switch x, reading switch y status.
// - Prewarning flag follows the thermal prewarning comparator with its hysteresis.
// - Prewarning flag is on the data line at the falling edge of select.
// - A frame aborted before sixteen bits leaves both registers unchanged.
// - Thermal shutdown disables the output, clears its status bit, sets overload.
// - Thermally disabled output returns only when cool and status reset is written.
// - Overcurrent shutdown is armed only while its enable bit is high.
// - Armed overcurrent beyond trip delay switches off, sets overload, clears status.
// - With enable low, overcurrent neither switches off nor sets overload.
// - Status reset clears overload and re-enables outputs disabled by overcurrent, or by a thermal stop once cool.
// - Sleep control 0 turns all outputs off, link stays alive; 1 restores them.
// - The common PWM pin gates selected switches only when their switch-on bit is set.
// - Output bit 13 is the overload flag.
// - Output bit 14 is the inverse of sleep control, high in standby.
// - Output bit 15 holds the supply-fail flag.
module hbfc_fault_ctrl
    import hbfc_pkg::*;
#(
    parameter int OC_TRIP_DELAY_NS = OC_DELAY_NS_DEF
)
(
    input  wire logic                CLK_SYS_I,
    input  wire logic                RSTN_I,
    input  wire logic                SPI_CLK_I,
    input  wire logic                CS_N_I,
    input  wire logic                DI_I,
    output logic                     DO_O,
    input  wire logic                PWM_I,
    input  wire logic                UV_I,
    input  wire logic                PREWARN_I,
    input  wire logic [NUM_SW-1:0]   TSD_I,
    input  wire logic [NUM_SW-1:0]   OC_I,
    input  wire logic [NUM_SW-1:0]   OL_I,
    output logic      [NUM_SW-1:0]   SW_ON_O,
    output logic      [NUM_SW-1:0]   OL_SRC_O,
    output logic      [WORD_W-1:0]   STATUS_O
);

    // Overcurrent trip delay in system cycles, rounded up
    localparam int              OC_CYC  = (OC_TRIP_DELAY_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam logic [15:0]     OC_LAST = 16'(((OC_CYC < 1) ? 1 : OC_CYC) - 1);

    // Link-side wires
    logic [WORD_W-1:0]  link_word;
    logic               link_tgl;

    // Pin synchroniser: first stage feeds only the second
    logic [PIN_W-1:0]   pin_raw;
    logic [PIN_W-1:0]   pin_s1_q;
    logic [PIN_W-1:0]   pin_s2_q;
    logic               tgl_seen_q;

    // Synchronised pins
    logic               cs_n_s;
    logic               tgl_s;
    logic               pwm_s;
    logic               uv_s;
    logic               prewarn_s;
    logic [NUM_SW-1:0]  tsd_s;
    logic [NUM_SW-1:0]  oc_s;
    logic [NUM_SW-1:0]  ol_s;

    // Input register and word acceptance
    hbfc_ctrl_type      ctrl_q;
    hbfc_ctrl_type      ctrl_d;
    hbfc_ctrl_type      new_word;
    logic               pend_q;
    logic               pend_d;
    logic               tgl_edge;
    logic               accept;
    logic               is_test_pat;
    logic               clr_q;
    logic               clr_d;

    // Protection state
    logic [UV_CNT_W-1:0] uv_cnt_q;
    logic [UV_CNT_W-1:0] uv_cnt_d;
    logic               uv_act_q;
    logic               uv_act_d;
    logic               uvf_q;
    logic               uvf_d;
    logic               ovd_q;
    logic               ovd_d;
    logic               uv_trip;
    logic [NUM_SW-1:0]  dis_q;
    logic [NUM_SW-1:0]  dis_d;
    logic [NUM_SW-1:0]  trip;
    logic [NUM_SW-1:0]  oc_trip;
    logic [NUM_SW-1:0]  sw_req;
    logic [NUM_SW-1:0]  sw_en;
    logic [NUM_SW-1:0]  sw_q;
    logic [NUM_SW-1:0]  ol_src;
    logic [NUM_SW-1:0]  ol_src_q;
    logic [NUM_SW-1:0]  sw_status;

    // Status word and its frozen copy for the link
    hbfc_status_type    status;
    logic [WORD_W-1:0]  snap_q;
    logic [WORD_W-1:0]  snap_d;

    // Reserved pattern check, used on every accepted word
    function automatic logic hbfc_is_test(input logic [WORD_W-1:0] w);
        hbfc_is_test = (w == TEST_PAT_A) || (w == TEST_PAT_B) || (w == TEST_PAT_C);
    endfunction

    // Serial link on its own clock
    hbfc_spi_link u_link (
        .spi_clk_i  (SPI_CLK_I),
        .rst_n_i    (RSTN_I),
        .cs_n_i     (CS_N_I),
        .di_i       (DI_I),
        .snap_i     (snap_q),
        .word_o     (link_word),
        .done_tgl_o (link_tgl),
        .do_o       (DO_O)
    );

    // Select, PWM, supply and sense pins and the link toggle pass two flops
    assign pin_raw = {CS_N_I, link_tgl, PWM_I, UV_I, PREWARN_I, TSD_I, OC_I, OL_I};

    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            pin_s1_q   <= '0;
            pin_s2_q   <= '0;
            tgl_seen_q <= 1'b0;
        end else begin
            pin_s1_q   <= pin_raw;
            pin_s2_q   <= pin_s1_q;
            tgl_seen_q <= tgl_s;
        end
    end

    // Unpack synchronised pins
    assign cs_n_s    = pin_s2_q[22];
    assign tgl_s     = pin_s2_q[21];
    assign pwm_s     = pin_s2_q[20];
    assign uv_s      = pin_s2_q[19];
    assign prewarn_s = pin_s2_q[18];
    assign tsd_s     = pin_s2_q[17:12];
    assign oc_s      = pin_s2_q[11:6];
    assign ol_s      = pin_s2_q[5:0];

    // Word acceptance waits for select to be back high; aborted frames never toggle
    assign tgl_edge    = tgl_s ^ tgl_seen_q;
    assign new_word    = hbfc_ctrl_type'(link_word);
    assign is_test_pat = hbfc_is_test(link_word);
    assign accept      = (pend_q | tgl_edge) & cs_n_s;
    assign pend_d      = (pend_q | tgl_edge) & ~cs_n_s;

    // Reserved patterns are dropped rather than acted on
    always_comb begin
        ctrl_d = ctrl_q;
        clr_d  = 1'b0;
        if (accept && !is_test_pat) begin
            ctrl_d              = new_word;
            ctrl_d.status_reset = 1'b0;
            clr_d               = new_word.status_reset;
        end
    end

    // Input register wakes with its three top bits high
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            ctrl_q <= hbfc_ctrl_type'(CTRL_RESET);
            pend_q <= 1'b0;
            clr_q  <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            pend_q <= pend_d;
            clr_q  <= clr_d;
        end
    end

    // Undervoltage filter: count only while the condition persists
    assign uv_trip  = uv_s && (uv_cnt_q == UV_LAST);
    assign uv_cnt_d = !uv_s ? '0 : (uv_trip ? uv_cnt_q : uv_cnt_q + 10'h001);
    // Disable is released the moment the supply is back, no command needed
    assign uv_act_d = uv_s & (uv_act_q | uv_trip);
    // Supply-fail stays set; a new event beats a clear in the same cycle
    assign uvf_d    = uv_act_d | (uvf_q & ~clr_q);

    // Per-switch overcurrent timer and protection latch
    generate
        for (genvar k = 0; k < NUM_SW; k++) begin : g_sw
            logic [OC_CNT_W-1:0] oc_cnt_q;
            logic [OC_CNT_W-1:0] oc_cnt_d;
            logic                oc_run;

            // Timer runs only while armed, driven and over the limit
            assign oc_run     = oc_s[k] & ctrl_q.oc_en & sw_q[k];
            assign oc_trip[k] = oc_run && (oc_cnt_q == OC_LAST);
            assign oc_cnt_d   = !oc_run ? '0 : (oc_trip[k] ? oc_cnt_q : oc_cnt_q + 16'h0001);

            always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
                if (!RSTN_I) begin
                    oc_cnt_q <= '0;
                end else begin
                    oc_cnt_q <= oc_cnt_d;
                end
            end

            // Thermal or overcurrent trip latches the disable; reset clears only a cool switch
            assign trip[k]  = tsd_s[k] | oc_trip[k];
            assign dis_d[k] = trip[k] | (dis_q[k] & ~(clr_q & ~tsd_s[k]));

            // PWM gates a selected switch only when its switch-on bit is set
            assign sw_req[k] = ctrl_q.sw_on[k] & (~ctrl_q.pwm_sel[k] | pwm_s);
            assign sw_en[k]  = sw_req[k] & ctrl_q.sleep_ctl & ~uv_act_q & ~dis_q[k];

            // Sensing source is dropped on a commanded switch, only that one
            assign ol_src[k] = ~ctrl_q.ol_test & ~ctrl_q.sw_on[k];

            // Commanded switch reports healthy unless disabled; idle switch reports sensing
            assign sw_status[k] = ctrl_q.sw_on[k] ? ~dis_q[k] : (ol_src[k] & ol_s[k]);
        end
    endgenerate

    // Overload set by any trip; a trip beats a reset in the same cycle
    assign ovd_d = (|trip) | (ovd_q & ~clr_q);

    // Protection and drive flops; drive and source outputs are registered
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            uv_cnt_q <= '0;
            uv_act_q <= 1'b0;
            uvf_q    <= 1'b0;
            ovd_q    <= 1'b0;
            dis_q    <= '0;
            sw_q     <= '0;
            ol_src_q <= '0;
        end else begin
            uv_cnt_q <= uv_cnt_d;
            uv_act_q <= uv_act_d;
            uvf_q    <= uvf_d;
            ovd_q    <= ovd_d;
            dis_q    <= dis_d;
            sw_q     <= sw_en;
            ol_src_q <= ol_src;
        end
    end

    // Output register content
    assign status.supply_fail = uvf_q;
    assign status.standby     = ~ctrl_q.sleep_ctl;
    assign status.overload    = ovd_q;
    assign status.unused      = UNUSED_ZERO;
    assign status.sw_status   = sw_status;
    assign status.prewarn     = prewarn_s;

    // Snapshot only moves while select is high, so the link never sees it change mid-frame
    assign snap_d = cs_n_s ? WORD_W'(status) : snap_q;

    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            snap_q <= '0;
        end else begin
            snap_q <= snap_d;
        end
    end

    assign SW_ON_O  = sw_q;
    assign OL_SRC_O = ol_src_q;
    assign STATUS_O = snap_q;

endmodule

//--- hbfc_fault_ctrl_sva.sv
// Checker: timing relations of the half-bridge fault control seen at its top ports.
module hbfc_fault_ctrl_sva
    import hbfc_pkg::*;
#(
    parameter int OC_TRIP_DELAY_NS = OC_DELAY_NS_DEF
)
(
    input wire logic              CLK_SYS_I,
    input wire logic              RSTN_I,
    input wire logic              CS_N_I,
    input wire logic              DO_O,
    input wire logic              UV_I,
    input wire logic [NUM_SW-1:0] TSD_I,
    input wire logic [NUM_SW-1:0] SW_ON_O,
    input wire logic [NUM_SW-1:0] OL_SRC_O,
    input wire logic [WORD_W-1:0] STATUS_O
);
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (!RSTN_I);

    logic [9:0]        uv_cnt_q;
    logic [9:0]        cs_cnt_q;
    logic [9:0]        tsd_cnt_q;
    logic [NUM_SW-1:0] tsd_q;

    // Run lengths of steady inputs; saturating so a long wait never wraps into a false pass
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            uv_cnt_q  <= 10'h000;
            cs_cnt_q  <= 10'h000;
            tsd_cnt_q <= 10'h000;
            tsd_q     <= 6'h00;
        end else begin
            uv_cnt_q  <= UV_I ? uv_cnt_q + 10'(uv_cnt_q != 10'h3FF) : 10'h000;
            cs_cnt_q  <= CS_N_I ? cs_cnt_q + 10'(cs_cnt_q != 10'h3FF) : 10'h000;
            tsd_cnt_q <= (TSD_I == tsd_q && TSD_I != 6'h00) ? tsd_cnt_q + 10'(tsd_cnt_q != 10'h3FF) : 10'h000;
            tsd_q     <= TSD_I;
        end
    end

    a_rst_quiet: assert property ($rose(RSTN_I) |-> SW_ON_O == 6'h00 && STATUS_O[15:13] == 3'h0)
        else $error("outputs not quiet after reset");
    a_uv_disable: assert property (uv_cnt_q >= 10'h208 |-> SW_ON_O == 6'h00)
        else $error("outputs on during long undervoltage");
    a_fail_set: assert property (uv_cnt_q >= 10'h208 && cs_cnt_q >= 10'h008 |-> STATUS_O[15])
        else $error("supply fail flag missing");
    a_fail_hold: assert property ($fell(STATUS_O[15]) |-> CS_N_I && $past(CS_N_I, 2))
        else $error("supply fail flag cleared without a word");
    a_src_yield: assert property ((OL_SRC_O & SW_ON_O) == 6'h00)
        else $error("sense source stays on a driven output");
    a_tsd_off: assert property (tsd_cnt_q >= 10'h008 |-> (tsd_q & SW_ON_O) == 6'h00)
        else $error("hot output still driven");
    a_tsd_overload: assert property (tsd_cnt_q >= 10'h008 && cs_cnt_q >= 10'h008 |-> STATUS_O[13])
        else $error("overload flag missing on thermal stop");
    a_do_prewarn: assert property ($fell(CS_N_I) |-> ##4 DO_O == STATUS_O[0])
        else $error("prewarning not on data out at select");

    c_uv_trip: cover property (uv_cnt_q == 10'h208);
    c_frame: cover property ($fell(CS_N_I));
    c_tsd_trip: cover property (tsd_cnt_q == 10'h008);
endmodule

bind hbfc_fault_ctrl hbfc_fault_ctrl_sva #(.OC_TRIP_DELAY_NS(OC_TRIP_DELAY_NS)) u_sva (
    .CLK_SYS_I(CLK_SYS_I),
    .RSTN_I   (RSTN_I),
    .CS_N_I   (CS_N_I),
    .DO_O     (DO_O),
    .UV_I     (UV_I),
    .TSD_I    (TSD_I),
    .SW_ON_O  (SW_ON_O),
    .OL_SRC_O (OL_SRC_O),
    .STATUS_O (STATUS_O)
);

//--- hbfc_mcu_model.sv
// Controller model: serial master that frames 16-bit words and reads the status back.
module hbfc_mcu_model (
    output logic      spi_clk_o,
    output logic      cs_n_o,
    output logic      di_o,
    input  wire logic do_i
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle: select high, serial clock parked low
    initial begin
        spi_clk_o = 1'b0;
        cs_n_o    = 1'b1;
        di_o      = 1'b0;
    end

    // One frame, LSB first; fewer than 16 bits aborts it early
    task automatic xfer(input logic [15:0] w, input int nbits, output logic [15:0] rx);
        rx = 16'h0000;
        cs_n_o = 1'b0;
        #100;
        for (int k = 0; k < nbits; k++) begin
            rx[k] = do_i;
            di_o = w[k];
            #24 spi_clk_o = 1'b1;
            #24 spi_clk_o = 1'b0;
        end
        #24 cs_n_o = 1'b1;
        di_o = ~di_o; // Released line must not keep stale data
        #100;
    endtask
endmodule

//--- hbfc_pkg.sv
// Package: field layouts, reset values, reserved patterns and timing counts of the half-bridge fault control.
package hbfc_pkg;

    // Input register as written by the controller, bit 0 first, bit 15 last
    typedef struct packed {
        logic       sleep_ctl;      // Bit 15: 1 = outputs active, 0 = standby
        logic       oc_en;          // Bit 14: overcurrent shutdown enable
        logic       ol_test;        // Bit 13: open-load test control, low = sensing on
        logic [5:0] pwm_sel;        // Bits 12..7: low/high PWM select per switch
        logic [5:0] sw_on;          // Bits 6..1: low/high switch-on per switch
        logic       status_reset;   // Bit 0: status reset command, one-shot
    } hbfc_ctrl_type;

    // Output register as read back by the controller
    typedef struct packed {
        logic       supply_fail;    // Bit 15: supply-fail flag
        logic       standby;        // Bit 14: standby indicator
        logic       overload;       // Bit 13: overload flag
        logic [5:0] unused;         // Bits 12..7: read as zero
        logic [5:0] sw_status;      // Bits 6..1: per-switch status / open-load
        logic       prewarn;        // Bit 0: thermal prewarning flag
    } hbfc_status_type;

    // Word widths and bit counts
    localparam int          WORD_W       = 16;
    localparam int          CNT_W        = 5;
    localparam int          NUM_SW       = 6;
    localparam logic [4:0]  LAST_BIT     = 5'h0F;
    localparam logic [4:0]  FULL_WORD    = 5'h10;

    // Power-on value and reserved test patterns of the input register
    localparam logic [15:0] CTRL_RESET   = 16'hE000;
    localparam logic [15:0] TEST_PAT_A   = 16'hF800;
    localparam logic [15:0] TEST_PAT_B   = 16'hE600;
    localparam logic [15:0] TEST_PAT_C   = 16'hE180;
    localparam logic [5:0]  UNUSED_ZERO  = 6'h00;

    // System clock and undervoltage filter
    localparam int          SYS_CLK_PERIOD_NS = 20;
    localparam int          UV_DELAY_NS       = 10000;
    localparam int          UV_DELAY_CYC      = (UV_DELAY_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam int          UV_CNT_W          = 10;
    localparam logic [9:0]  UV_LAST           = 10'(UV_DELAY_CYC - 1);

    // Default overcurrent trip delay; counter width for it
    localparam int          OC_DELAY_NS_DEF   = 10000;
    localparam int          OC_CNT_W          = 16;

    // Width of the pin synchroniser bundle
    localparam int          PIN_W             = 23;

endpackage

//--- hbfc_spi_link.sv
// Serial link end of the half-bridge fault control, clocked by the controller's serial clock.
module hbfc_spi_link
    import hbfc_pkg::*;
(
    input  wire logic                spi_clk_i,
    input  wire logic                rst_n_i,
    input  wire logic                cs_n_i,
    input  wire logic                di_i,
    input  wire logic [WORD_W-1:0]   snap_i,
    output logic      [WORD_W-1:0]   word_o,
    output logic                     done_tgl_o,
    output logic                     do_o
);

    logic [CNT_W-1:0]   cnt_q;
    logic [WORD_W-1:0]  sh_q;
    logic [WORD_W-1:0]  word_q;
    logic               tgl_q;
    logic               frame_rst_n;
    logic               last_edge;

    // The frame's own select ends it: counter and shifter clear while select is high
    assign frame_rst_n = rst_n_i & ~cs_n_i;
    assign last_edge   = (cnt_q == LAST_BIT);

    // Shift in least significant bit first, counter saturates after one word
    always_ff @(posedge spi_clk_i or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            cnt_q <= '0;
            sh_q  <= '0;
        end else begin
            if (cnt_q != FULL_WORD) begin
                cnt_q <= cnt_q + 5'h01;
            end
            sh_q <= {di_i, sh_q[WORD_W-1:1]};
        end
    end

    // Word captured and announced by toggle only on the sixteenth edge
    always_ff @(posedge spi_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            word_q <= '0;
            tgl_q  <= 1'b0;
        end else if (last_edge) begin
            word_q <= {di_i, sh_q[WORD_W-1:1]};
            tgl_q  <= ~tgl_q;
        end
    end

    // Bit 0 (prewarning) is on the data line as soon as select falls, no edge needed
    assign do_o       = (cnt_q == FULL_WORD) ? 1'b0 : snap_i[cnt_q[3:0]];
    assign word_o     = word_q;
    assign done_tgl_o = tgl_q;

endmodule
